// ==== rre_exec_map.vh ====
/*
 * Constants for the return and rotate execution block: instruction
 * selects, widths, field positions, cycle counts and reset values.
 * Assumes inclusion by bare name from the design file and the bench top.
 */
`ifndef RRE_EXEC_MAP_VH
`define RRE_EXEC_MAP_VH

// ----------------------------------------
// Instruction selects
// ----------------------------------------
`define RRE_OP_NONE 3'h0
`define RRE_OP_IRQ_EXIT 3'h1
`define RRE_OP_LIT_EXIT 3'h2
`define RRE_OP_SUB_EXIT 3'h3
`define RRE_OP_ROT_LEFT 3'h4

// ----------------------------------------
// Widths and field positions
// ----------------------------------------
`define RRE_PC_W 15
`define RRE_FADDR_W 7
`define RRE_IRQ_EN_BIT 7

// ----------------------------------------
// Cycle counts and reset values
// ----------------------------------------
`define RRE_RET_CYCLES 2'h2
`define RRE_ROT_CYCLES 2'h1
`define RRE_PC_RST 15'h0000
`define RRE_BYTE_RST 8'h00
`define RRE_FADDR_RST 7'h00

`endif

// ==== rre_exec.v ====
/*
 * Execution unit for the interrupt exit, literal exit, subroutine exit
 * and rotate-left-through-carry instructions.
 * Assumes the decode stage presents one instruction per issue pulse,
 * only while busy is low, and that the stack and file register data
 * are valid in the cycle of issue.
 */
// Function
// [RQ1] Interrupt exit pops the stack, loads the top entry into the program counter and sets the global enable.
// [RQ2] The global enable sits at bit 7 of the interrupt control register and the interrupt exit takes two cycles.
// [RQ3] Literal exit writes its 8-bit literal into the working register.
// [RQ4] Literal exit also pops the stack into the program counter, in one word and two cycles.
// [RQ5] Subroutine exit has no operands and pops the stack into the program counter over two cycles.
// [RQ6] Rotate left moves old carry into bit 0 and old bit 7 into the carry.
// [RQ7] Rotate left writes the working register when the destination select is 0, the file register when 1.
// [RQ8] Rotate left takes one word and one cycle and changes only the carry among the status bits.
`include "rre_exec_map.vh"

module rre_exec (
    // Clock, reset, enable
    input wire clock,
    input wire nrst,
    input wire clk_en,
    // Decoded instruction
    input wire issue,
    input wire [2:0] op_sel,
    input wire [7:0] literal,
    input wire [6:0] file_addr,
    input wire dest_sel,
    // Core state inputs
    input wire [14:0] stack_top_entry,
    input wire [7:0] file_data,
    input wire carry_in,
    input wire [7:0] irq_control_reg,
    // Execution outputs
    output reg busy,
    output reg done,
    output reg stack_pop,
    output reg pc_load,
    output reg [14:0] pc_value,
    output reg w_write,
    output reg [7:0] w_value,
    output reg file_write,
    output reg [6:0] file_waddr,
    output reg [7:0] file_wdata,
    output reg carry_write,
    output reg carry_out,
    output reg irq_ctl_write,
    output reg [7:0] irq_ctl_value
);

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    function [8:0] rre_rotl;
        input [7:0] val;
        input cin;
        begin
            rre_rotl = {val, cin};
        end
    endfunction

    function rre_op_is;
        input [2:0] op;
        input [2:0] code;
        begin
            rre_op_is = (op == code);
        end
    endfunction

    function [7:0] rre_set_irq_en;
        input [7:0] ctl;
        begin
            rre_set_irq_en = ctl | (8'h01 << `RRE_IRQ_EN_BIT);
        end
    endfunction

    // ----------------------------------------
    // Sequencer state
    // ----------------------------------------
    localparam ST_IDLE = 1'h0;
    localparam ST_WAIT = 1'h1;

    reg state_r;
    reg state_nxt;
    reg [1:0] cnt_r;
    reg [1:0] cnt_nxt;
    reg [8:0] rot;
    reg is_ret;
    reg is_irq;
    reg is_lit;
    reg is_rot;
    reg take_ret;
    reg take_rot;
    reg finish;

    // ----------------------------------------
    // Decode of the presented instruction
    // ----------------------------------------
    always @* begin
        rot = rre_rotl(file_data, carry_in); // RQ6
        is_irq = rre_op_is(op_sel, `RRE_OP_IRQ_EXIT);
        is_lit = rre_op_is(op_sel, `RRE_OP_LIT_EXIT);
        is_ret = is_irq || is_lit || rre_op_is(op_sel, `RRE_OP_SUB_EXIT);
        is_rot = rre_op_is(op_sel, `RRE_OP_ROT_LEFT);
        take_ret = issue && (state_r == ST_IDLE) && is_ret;
        take_rot = issue && (state_r == ST_IDLE) && is_rot;
        finish = (state_r == ST_WAIT) && (cnt_r == `RRE_ROT_CYCLES);
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always @* begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            ST_IDLE: begin
                if (take_ret) begin
                    state_nxt = ST_WAIT;
                    cnt_nxt = `RRE_RET_CYCLES - 2'h1; // RQ2 RQ4 RQ5
                end
            end
            ST_WAIT: begin
                cnt_nxt = cnt_r - 2'h1;
                if (finish) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
            cnt_r <= 2'h0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // ----------------------------------------
    // Busy and done
    // ----------------------------------------
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            busy <= 1'h0;
            done <= 1'h0;
        end else if (clk_en) begin
            busy <= (state_nxt == ST_WAIT); // RQ2 RQ4 RQ5
            done <= take_rot || finish; // RQ2 RQ8
        end
    end

    // ----------------------------------------
    // Stack pop and program counter load
    // ----------------------------------------
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            stack_pop <= 1'h0;
            pc_load <= 1'h0;
            pc_value <= `RRE_PC_RST;
        end else if (clk_en) begin
            stack_pop <= take_ret; // RQ1 RQ4 RQ5
            pc_load <= take_ret;
            if (take_ret) begin
                pc_value <= stack_top_entry; // RQ1 RQ4 RQ5
            end
        end
    end

    // ----------------------------------------
    // Working register write
    // ----------------------------------------
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            w_write <= 1'h0;
            w_value <= `RRE_BYTE_RST;
        end else if (clk_en) begin
            w_write <= (take_ret && is_lit) || (take_rot && !dest_sel); // RQ3 RQ7
            if (take_ret && is_lit) begin
                w_value <= literal; // RQ3
            end else if (take_rot && !dest_sel) begin
                w_value <= rot[7:0]; // RQ6 RQ7
            end
        end
    end

    // ----------------------------------------
    // File register write
    // ----------------------------------------
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            file_write <= 1'h0;
            file_waddr <= `RRE_FADDR_RST;
            file_wdata <= `RRE_BYTE_RST;
        end else if (clk_en) begin
            file_write <= take_rot && dest_sel; // RQ7
            if (take_rot && dest_sel) begin
                file_waddr <= file_addr; // RQ7
                file_wdata <= rot[7:0]; // RQ6 RQ7
            end
        end
    end

    // ----------------------------------------
    // Carry flag write
    // ----------------------------------------
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            carry_write <= 1'h0;
            carry_out <= 1'h0;
        end else if (clk_en) begin
            carry_write <= take_rot; // RQ8
            if (take_rot) begin
                carry_out <= rot[8]; // RQ6
            end
        end
    end

    // ----------------------------------------
    // Interrupt control write
    // ----------------------------------------
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_ctl_write <= 1'h0;
            irq_ctl_value <= `RRE_BYTE_RST;
        end else if (clk_en) begin
            irq_ctl_write <= take_ret && is_irq; // RQ1 RQ2
            if (take_ret && is_irq) begin
                irq_ctl_value <= rre_set_irq_en(irq_control_reg); // RQ1 RQ2
            end
        end
    end

endmodule

// ==== rre_core_mdl.sv ====
/* Core-side model: stack, one file register, carry and irq control. Assumes one rre_exec on the same clock. */
module rre_core_mdl (
    input logic clock, nrst, stack_pop, carry_write, carry_out, file_write, irq_ctl_write,
    input logic [7:0] file_wdata, irq_ctl_value,
    output logic [14:0] stack_top_entry,
    output logic [7:0] file_data, irq_control_reg,
    output logic carry_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] sp_r;
    assign stack_top_entry = {sp_r, 11'h5A3};
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sp_r <= 4'h0;
            file_data <= 8'hE6;
            carry_in <= 1'b0;
            irq_control_reg <= 8'h15;
        end else begin
            if (stack_pop) sp_r <= sp_r + 4'h1;
            if (file_write) file_data <= file_wdata;
            if (carry_write) carry_in <= carry_out;
            if (irq_ctl_write) irq_control_reg <= irq_ctl_value;
        end
    end
endmodule

// ==== rre_exec_chk.sv ====
/* Port checker for rre_exec. Assumes a bind from the bench top. */
module rre_exec_chk (
    input logic clock, nrst, clk_en, issue, dest_sel, carry_in, busy, done, stack_pop, pc_load,
    input logic w_write, file_write, carry_write, carry_out, irq_ctl_write,
    input logic [2:0] op_sel,
    input logic [7:0] literal, file_data, irq_control_reg, w_value, file_wdata, irq_ctl_value,
    input logic [14:0] stack_top_entry, pc_value
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    wire t = issue && clk_en && !busy;
    wire r = t && op_sel inside {3'h1, 3'h2, 3'h3};
    wire q = t && op_sel == 3'h4;
    a_ret_pop: assert property (r |=> stack_pop && pc_load && busy && pc_value == $past(stack_top_entry))
        else $error("return pop wrong");
    a_ret_two: assert property (r |=> !done ##1 done && !busy) else $error("return length wrong");
    a_irq_en_set: assert property (t && op_sel == 3'h1 |=> irq_ctl_write && irq_ctl_value == ($past(irq_control_reg) | 8'h80))
        else $error("enable not set");
    a_lit_w: assert property (t && op_sel == 3'h2 |=> w_write && w_value == $past(literal)) else $error("literal wrong");
    a_sub_only: assert property (t && op_sel == 3'h3 |=> !w_write && !irq_ctl_write) else $error("extra write");
    a_rot_c: assert property (q |=> carry_write && done && carry_out == $past(file_data[7])) else $error("carry wrong");
    a_rot_dst: assert property (q |=> w_write == !$past(dest_sel) && file_write == $past(dest_sel)) else $error("dest wrong");
    a_rot_val: assert property (q && dest_sel |=> file_wdata == {$past(file_data[6:0]), $past(carry_in)})
        else $error("rotate value wrong");
    a_rot_one: assert property (q |=> !stack_pop && !pc_load && !busy) else $error("rotate not single");
    a_rot_w: assert property (q && !dest_sel |=> w_value == {$past(file_data[6:0]), $past(carry_in)})
        else $error("rotate w value wrong");
    a_busy_ign: assert property (issue && clk_en && busy |=> !stack_pop && !carry_write && !file_write)
        else $error("issue taken while busy");
    a_hold_frz: assert property (!clk_en |=> $stable({busy, done, pc_value, w_value}))
        else $error("state moved while frozen");
    c_irq: cover property (t && op_sel == 3'h1);
    c_lit: cover property (t && op_sel == 3'h2);
    c_rot: cover property (q && dest_sel);
    c_hold: cover property (!clk_en && issue);
endmodule

// ==== tb_top.sv ====
/* Bench for rre_exec with the core model. Assumes the design header is on the include path. */
`include "rre_exec_map.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 0, nrst = 0, issue = 0, dest_sel = 0, carry_in, busy, done, stack_pop, pc_load, w_write;
    logic clk_en = 1;
    logic file_write, carry_write, carry_out, irq_ctl_write;
    logic [2:0] op_sel = 0;
    logic [6:0] file_addr = 0, file_waddr;
    logic [7:0] literal = 0, file_data, irq_control_reg, w_value, file_wdata, irq_ctl_value;
    logic [14:0] stack_top_entry, pc_value;
    int num_errors = 0, n_compared = 0;
    rre_exec uut (.clock(clock), .nrst(nrst), .clk_en(clk_en), .issue(issue), .op_sel(op_sel), .literal(literal),
        .file_addr(file_addr), .dest_sel(dest_sel), .stack_top_entry(stack_top_entry), .file_data(file_data),
        .carry_in(carry_in), .irq_control_reg(irq_control_reg), .busy(busy), .done(done), .stack_pop(stack_pop),
        .pc_load(pc_load), .pc_value(pc_value), .w_write(w_write), .w_value(w_value), .file_write(file_write),
        .file_waddr(file_waddr), .file_wdata(file_wdata), .carry_write(carry_write), .carry_out(carry_out),
        .irq_ctl_write(irq_ctl_write), .irq_ctl_value(irq_ctl_value));
    rre_core_mdl mdl (.clock(clock), .nrst(nrst), .stack_pop(stack_pop), .carry_write(carry_write),
        .carry_out(carry_out), .file_write(file_write), .irq_ctl_write(irq_ctl_write), .file_wdata(file_wdata),
        .irq_ctl_value(irq_ctl_value), .stack_top_entry(stack_top_entry), .file_data(file_data),
        .irq_control_reg(irq_control_reg), .carry_in(carry_in));
    initial forever #5 clock = ~clock;
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task go(input logic [2:0] o, input logic [7:0] l, input logic d);
        @(negedge clock);
        issue = 1;
        op_sel = o;
        literal = l;
        dest_sel = d;
        @(negedge clock);
        issue = 0;
    endtask
    task print_verdict;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task t_ret;
        go(`RRE_OP_IRQ_EXIT, 8'h00, 0);
        chk("pc", 15'h05A3, pc_value);
        chk("busy", 1, busy);
        @(negedge clock);
        chk("done", 1, done);
        chk("irq_ctl", 8'h95, irq_control_reg);
        go(`RRE_OP_LIT_EXIT, 8'hFF, 0);
        chk("pc", 15'h0DA3, pc_value);
        chk("w", 8'hFF, w_value);
        @(negedge clock);
        chk("done", 1, done);
        go(`RRE_OP_SUB_EXIT, 8'h3C, 0);
        chk("pc", 15'h15A3, pc_value);
        chk("w_wr", 0, w_write);
        @(negedge clock);
        chk("done", 1, done);
    endtask
    task t_rot;
        file_addr = 7'h7F;
        go(`RRE_OP_ROT_LEFT, 8'h00, 0);
        chk("w", 8'hCC, w_value);
        chk("c", 1, carry_out);
        chk("f_wr", 0, file_write);
        chk("done", 1, done);
        go(`RRE_OP_ROT_LEFT, 8'h00, 1);
        chk("f", 8'hCD, file_wdata);
        chk("fa", 7'h7F, file_waddr);
        go(`RRE_OP_ROT_LEFT, 8'h00, 1);
        chk("f", 8'h9B, file_wdata);
        chk("pop", 0, stack_pop);
    endtask
    task t_busy;
        @(negedge clock);
        issue = 1;
        op_sel = `RRE_OP_SUB_EXIT;
        @(negedge clock);
        op_sel = `RRE_OP_ROT_LEFT;
        chk("pc", 15'h1DA3, pc_value);
        @(negedge clock);
        issue = 0;
        chk("done", 1, done);
        chk("c_wr", 0, carry_write);
        chk("f_wr", 0, file_write);
    endtask
    task t_hold;
        @(negedge clock);
        clk_en = 0;
        issue = 1;
        dest_sel = 0;
        @(negedge clock);
        chk("done", 0, done);
        chk("w_wr", 0, w_write);
        clk_en = 1;
        @(negedge clock);
        issue = 0;
        chk("w", 8'h37, w_value);
        chk("done", 1, done);
    endtask
    initial begin
        repeat (5) @(negedge clock);
        chk("rst", 0, {done, pc_load, w_write});
        nrst = 1;
        t_ret;
        t_rot;
        t_busy;
        t_hold;
        print_verdict;
    end
    initial begin
        #5000 num_errors++;
        print_verdict;
    end
endmodule
bind rre_exec rre_exec_chk u_chk (.*);
